// ---- core/tacf_top.sv ----
// Summary of operation
// - With alternation bit 31 clear, all sets of one point use Z1/Z2.
// - With alternation set, sets of one point may alternate Z1/Z2 and Z3/Z4.
// - Drive bit 30 selects single-ended internal (0) or differential external (1).
// - In touch mode, drive bit ignored for axis sequence 10, which always runs differentially.
// - Bits 29 to 19 read zero and ignore writes.
// - Valid-sample field picks 2nd to 8th sample; 000 reserved; default 010.
// - In touch mode readout bit 15 selects processor (0) or DMA (1).
// - Axis-sequence field applies only in touch mode, command 1100.
//
// Purpose: AHB-Lite configuration register and touch sequence field capture.
// Assumes: Single transfers of whole words, zero wait states.
// Notes:   Unmapped addresses read zero, writes there are dropped; response is OKAY.
`timescale 1ns/100ps
`default_nettype none
module tacf_top
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        seq_start,
    input  wire logic        seq_end,
    input  wire logic        set_done,
    output logic             plan_diff,
    output logic             plan_z34,
    output logic             plan_dma,
    output logic [1:0]       plan_axis,
    output logic [2:0]       plan_vsamp
);
    logic [31:0] cfg_q;
    logic [3:0]  cmd_q;
    logic        active_q;
    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;
    logic        rd_pend;
    logic [7:0]  rd_addr;
    logic        addr_ok;
    tacf_pkg::tacf_fields_t cap_q;
    logic        touch_q;

    tacf_cfg_if cfg_bus ();

    // A transfer is taken only when selected, ready and NONSEQ or SEQ; IDLE and BUSY slots are ignored.
    assign addr_ok = hsel && hready && htrans[1];
    assign rd_pend = addr_ok && !hwrite;
    assign rd_addr = haddr[7:0];

    // Address phase of a write is held so the data phase can store hwdata.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end
        else
        begin
            wr_pend_q <= addr_ok && hwrite && hsize == 3'h2;
            wr_addr_q <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cfg_q <= tacf_pkg::CFG_RESET;
        else if (wr_pend_q && wr_addr_q == tacf_pkg::CFG_OFFSET)
            cfg_q <= hwdata & tacf_pkg::CFG_WRITE_MASK;
    end

    // Only the command code is kept here; touch mode is decoded at capture time,
    // so a new command never alters a plan that is already running.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cmd_q <= 4'h0;
        else if (wr_pend_q && wr_addr_q == tacf_pkg::CMD_OFFSET)
            cmd_q <= hwdata[3:0];
    end

    // Read data is registered so it stands in the data phase right after the address phase.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (rd_pend)
            unique case (rd_addr)
                tacf_pkg::CFG_OFFSET:    hrdata <= cfg_q & tacf_pkg::CFG_WRITE_MASK;
                tacf_pkg::CMD_OFFSET:    hrdata <= {28'h0000000, cmd_q};
                tacf_pkg::ACTIVE_OFFSET: hrdata <= {31'h00000000, active_q};
                default:                 hrdata <= 32'h00000000;
            endcase
    end

    // The slave never stretches a transfer and never reports an error; the flops remain so that
    // both bus outputs come straight from registers, as every other output does.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Sequence-active flag; start wins over end if both arrive together.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            active_q <= 1'b0;
        else if (seq_start)
            active_q <= 1'b1;
        else if (seq_end)
            active_q <= 1'b0;
    end

    // Capture only at sequence start, so software writes cannot disturb a running sequence.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cap_q   <= '{1'b0, 1'b0, tacf_pkg::VSAMP_DEFAULT, 1'b0, tacf_pkg::AXIS_XY};
            touch_q <= 1'b0;
        end
        else if (seq_start)
        begin
            cap_q.z_pair_alternate   <= cfg_q[tacf_pkg::ZALT_BIT];
            cap_q.differential       <= cfg_q[tacf_pkg::DIFF_BIT];
            cap_q.valid_sample_index <= cfg_q[tacf_pkg::VSAMP_LSB +: 3];
            cap_q.dma_readout        <= cfg_q[tacf_pkg::DMA_BIT];
            cap_q.axis_sequence      <= cfg_q[tacf_pkg::AXIS_LSB +: 2];
            touch_q                  <= cmd_q == tacf_pkg::CMD_TOUCH;
        end
    end

    assign cfg_bus.fields     = cap_q;
    assign cfg_bus.touch_mode = touch_q;

    tacf_seq u_seq
    (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .cfg          (cfg_bus),
        .set_done     (set_done),
        .point_start  (seq_start),
        .plan_diff_q  (plan_diff),
        .plan_z34_q   (plan_z34),
        .plan_dma_q   (plan_dma),
        .plan_axis_q  (plan_axis),
        .plan_vsamp_q (plan_vsamp)
    );

    AST_RSVD_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
        cfg_q[29:19] == 11'h000)
        else $error("reserved bits set");

    AST_HOLD_CAPTURE: assert property (@(posedge hclk) disable iff (!hresetn)
        active_q && !seq_start |=> $stable(cap_q))
        else $error("capture changed mid sequence");

    AST_VSAMP_NZ: assert property (@(posedge hclk) disable iff (!hresetn)
        plan_vsamp != 3'h0)
        else $error("reserved sample code used");

    AST_DMA_TOUCH: assert property (@(posedge hclk) disable iff (!hresetn)
        plan_dma |-> $past(touch_q))
        else $error("dma outside touch mode");

    AST_AXIS_TOUCH: assert property (@(posedge hclk) disable iff (!hresetn)
        !touch_q |=> plan_axis == 2'h0)
        else $error("axis used outside touch");

    AST_DIFF_SEL: assert property (@(posedge hclk) disable iff (!hresetn)
        !(touch_q && cap_q.axis_sequence == tacf_pkg::AXIS_XYZZ) |=> plan_diff == $past(cap_q.differential))
        else $error("drive select");

    // A register write spans an address phase and a data phase, and a plan appears two edges
    // after its start pulse: one edge to capture, one to plan. Those steps are named once here
    // so that every property below counts the edges the same way.
    sequence s_cfg_write_addr;
        addr_ok && hwrite && hsize == 3'h2 && haddr[7:0] == tacf_pkg::CFG_OFFSET;
    endsequence

    sequence s_cfg_write;
        s_cfg_write_addr ##1 1'b1;
    endsequence

    sequence s_cmd_write_addr;
        addr_ok && hwrite && hsize == 3'h2 && haddr[7:0] == tacf_pkg::CMD_OFFSET;
    endsequence

    sequence s_cmd_write;
        s_cmd_write_addr ##1 1'b1;
    endsequence

    sequence s_cfg_bypass_addr;
        addr_ok && hwrite && (hsize != 3'h2 || haddr[7:0] != tacf_pkg::CFG_OFFSET);
    endsequence

    sequence s_cfg_read_addr;
        rd_pend && rd_addr == tacf_pkg::CFG_OFFSET;
    endsequence

    sequence s_active_read_addr;
        rd_pend && rd_addr == tacf_pkg::ACTIVE_OFFSET;
    endsequence

    sequence s_capture;
        seq_start ##1 1'b1;
    endsequence

    sequence s_capture_code;
        (seq_start && cfg_q[tacf_pkg::VSAMP_LSB +: 3] != tacf_pkg::VSAMP_RESERVED) ##1 1'b1;
    endsequence

    sequence s_capture_reserved;
        (seq_start && cfg_q[tacf_pkg::VSAMP_LSB +: 3] == tacf_pkg::VSAMP_RESERVED) ##1 1'b1;
    endsequence

    sequence s_capture_xyzz;
        (seq_start && cmd_q == tacf_pkg::CMD_TOUCH
            && cfg_q[tacf_pkg::AXIS_LSB +: 2] == tacf_pkg::AXIS_XYZZ) ##1 1'b1;
    endsequence

    AST_CFG_STORE: assert property (@(posedge hclk) disable iff (!hresetn)
        s_cfg_write |=> cfg_q == ($past(hwdata) & tacf_pkg::CFG_WRITE_MASK))
        else $error("configuration write lost");

    // A dropped write must leave the register alone at the edge that would have stored it.
    AST_CFG_KEEP: assert property (@(posedge hclk) disable iff (!hresetn)
        s_cfg_bypass_addr |-> ##2 $stable(cfg_q))
        else $error("configuration changed by dropped write");

    AST_CFG_READ: assert property (@(posedge hclk) disable iff (!hresetn)
        s_cfg_read_addr |=> hrdata == ($past(cfg_q) & tacf_pkg::CFG_WRITE_MASK))
        else $error("configuration read wrong");

    AST_CFG_READ_RSVD: assert property (@(posedge hclk) disable iff (!hresetn)
        s_cfg_read_addr |=> hrdata[29:19] == 11'h000)
        else $error("reserved bits read nonzero");

    AST_CMD_STORE: assert property (@(posedge hclk) disable iff (!hresetn)
        s_cmd_write |=> cmd_q == $past(hwdata[3:0]))
        else $error("command write lost");

    AST_ACTIVE_READ: assert property (@(posedge hclk) disable iff (!hresetn)
        s_active_read_addr |=> hrdata == {31'h00000000, $past(active_q)})
        else $error("active flag read wrong");

    AST_ACTIVE_SET: assert property (@(posedge hclk) disable iff (!hresetn)
        seq_start |=> active_q)
        else $error("sequence not marked active");

    AST_ACTIVE_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
        seq_end && !seq_start |=> !active_q)
        else $error("sequence still marked active");

    AST_CAP_ZALT: assert property (@(posedge hclk) disable iff (!hresetn)
        seq_start |=> cap_q.z_pair_alternate == $past(cfg_q[tacf_pkg::ZALT_BIT]))
        else $error("alternation not captured");

    AST_CAP_TOUCH: assert property (@(posedge hclk) disable iff (!hresetn)
        seq_start |=> touch_q == ($past(cmd_q) == tacf_pkg::CMD_TOUCH))
        else $error("touch mode not captured");

    AST_Z_RESTART: assert property (@(posedge hclk) disable iff (!hresetn)
        seq_start |=> !plan_z34)
        else $error("new point not on first Z pair");

    AST_Z_TOGGLE: assert property (@(posedge hclk) disable iff (!hresetn)
        cap_q.z_pair_alternate && set_done && !seq_start |=> plan_z34 != $past(plan_z34))
        else $error("Z pair did not alternate");

    AST_VSAMP_PASS: assert property (@(posedge hclk) disable iff (!hresetn)
        s_capture_code |=> plan_vsamp == $past(cfg_q[tacf_pkg::VSAMP_LSB +: 3], 2))
        else $error("valid sample code not passed on");

    AST_VSAMP_RSVD: assert property (@(posedge hclk) disable iff (!hresetn)
        s_capture_reserved |=> plan_vsamp == tacf_pkg::VSAMP_DEFAULT)
        else $error("reserved sample code not replaced");

    AST_PLAN_DMA: assert property (@(posedge hclk) disable iff (!hresetn)
        s_capture |=> plan_dma == ($past(cfg_q[tacf_pkg::DMA_BIT], 2)
            && $past(cmd_q, 2) == tacf_pkg::CMD_TOUCH))
        else $error("readout route wrong");

    AST_PLAN_AXIS: assert property (@(posedge hclk) disable iff (!hresetn)
        s_capture |=> plan_axis == (($past(cmd_q, 2) == tacf_pkg::CMD_TOUCH)
            ? $past(cfg_q[tacf_pkg::AXIS_LSB +: 2], 2) : tacf_pkg::AXIS_XY))
        else $error("axis plan wrong");

    AST_PLAN_XYZZ: assert property (@(posedge hclk) disable iff (!hresetn)
        s_capture_xyzz |=> plan_diff)
        else $error("four set plan not differential");
endmodule
`default_nettype wire

// ---- core/tacf_pkg.sv ----
// Purpose: Shared constants and types for the touch converter configuration block.
// Assumes: 32-bit AHB-Lite register access, one aligned word per register.
// Notes:   Offsets of the status and command registers are local choices.
package tacf_pkg;
    localparam logic [7:0]  CFG_OFFSET      = 8'h04;
    localparam logic [7:0]  CMD_OFFSET      = 8'h00;
    localparam logic [7:0]  ACTIVE_OFFSET   = 8'h08;
    localparam int          ZALT_BIT        = 31;
    localparam int          DIFF_BIT        = 30;
    localparam int          VSAMP_LSB       = 16;
    localparam int          DMA_BIT         = 15;
    localparam int          AXIS_LSB        = 13;
    localparam logic [31:0] CFG_WRITE_MASK  = 32'hC007FFFF;
    localparam logic [31:0] CFG_RESET       = 32'h0002002C;
    localparam logic [3:0]  CMD_TOUCH       = 4'hC;
    localparam logic [2:0]  VSAMP_RESERVED  = 3'h0;
    localparam logic [2:0]  VSAMP_DEFAULT   = 3'h2;
    localparam logic [1:0]  AXIS_XY         = 2'h0;
    localparam logic [1:0]  AXIS_XYZ        = 2'h1;
    localparam logic [1:0]  AXIS_XYZZ       = 2'h2;

    typedef struct packed {
        logic       z_pair_alternate;
        logic       differential;
        logic [2:0] valid_sample_index;
        logic       dma_readout;
        logic [1:0] axis_sequence;
    } tacf_fields_t;

    function automatic logic [2:0] tacf_vsamp_clean(input logic [2:0] code);
        // Reserved code falls back to the default so the reported sample is always defined.
        tacf_vsamp_clean = (code == VSAMP_RESERVED) ? VSAMP_DEFAULT : code;
    endfunction
endpackage

// ---- core/tacf_cfg_if.sv ----
// Purpose: Carries captured configuration fields from the register file to the sequencer.
// Assumes: Single clock domain.
// Notes:   The register side drives, the sequencer side reads.
`timescale 1ns/100ps
`default_nettype none
interface tacf_cfg_if;
    tacf_pkg::tacf_fields_t fields;
    logic                   touch_mode;
    modport regs (output fields, output touch_mode);
    modport seq  (input fields, input touch_mode);
endinterface
`default_nettype wire

// ---- core/tacf_seq.sv ----
// Purpose: Decides the measurement plan for one touch point from the captured fields.
// Assumes: Fields are stable while a sequence runs.
// Notes:   Z pair alternation toggles between repeated sets of the same point.
`timescale 1ns/100ps
`default_nettype none
module tacf_seq
(
    input  wire logic          hclk,
    input  wire logic          hresetn,
    tacf_cfg_if.seq            cfg,
    input  wire logic          set_done,
    input  wire logic          point_start,
    output logic               plan_diff_q,
    output logic               plan_z34_q,
    output logic               plan_dma_q,
    output logic [1:0]         plan_axis_q,
    output logic [2:0]         plan_vsamp_q
);
    // Differential drive choice, forced for the four measurement sequence.
    // Outside touch mode the axis field has no effect, so it must not force the drive choice either.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            plan_diff_q <= 1'b0;
        else if (cfg.touch_mode && cfg.fields.axis_sequence == tacf_pkg::AXIS_XYZZ)
            plan_diff_q <= 1'b1;
        else
            plan_diff_q <= cfg.fields.differential;
    end

    // Z pair selection: fixed Z1/Z2 unless alternation is enabled.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            plan_z34_q <= 1'b0;
        else if (!cfg.fields.z_pair_alternate || point_start)
            plan_z34_q <= 1'b0;
        else if (set_done)
            plan_z34_q <= ~plan_z34_q;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            plan_dma_q   <= 1'b0;
            plan_axis_q  <= tacf_pkg::AXIS_XY;
            plan_vsamp_q <= tacf_pkg::VSAMP_DEFAULT;
        end
        else
        begin
            plan_dma_q   <= cfg.touch_mode & cfg.fields.dma_readout;
            plan_axis_q  <= cfg.touch_mode ? cfg.fields.axis_sequence : tacf_pkg::AXIS_XY;
            plan_vsamp_q <= tacf_pkg::tacf_vsamp_clean(cfg.fields.valid_sample_index);
        end
    end

    AST_ZFIXED: assert property (@(posedge hclk) disable iff (!hresetn)
        !cfg.fields.z_pair_alternate |=> !plan_z34_q)
        else $error("Z pair not fixed");
    AST_XYZZ_DIFF: assert property (@(posedge hclk) disable iff (!hresetn)
        cfg.touch_mode && cfg.fields.axis_sequence == tacf_pkg::AXIS_XYZZ |=> plan_diff_q)
        else $error("four set not differential");
endmodule
`default_nettype wire

// ---- test/tacf_panel.sv ----
// Purpose: Stand-in for the touch panel side, reporting finished measurement sets.
// Assumes: One clock; a set takes gap+1 cycles while the bench holds busy.
// Notes:   The panel stays silent while idle so no stray set toggles the Z pair.
`timescale 1ns/100ps
`default_nettype none
module tacf_panel
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       busy,
    input  wire logic [3:0] gap,
    output logic            set_done
);
    logic [3:0] cnt_q;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_q    <= 4'h0;
            set_done <= 1'b0;
        end
        else
        begin
            set_done <= busy && (cnt_q == gap);
            cnt_q    <= (!busy || cnt_q == gap) ? 4'h0 : cnt_q + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ---- test/touch_adc_config_fields_test.sv ----
// Purpose: Self-checking bench for the configuration register and plan capture.
// Assumes: Zero wait states are not relied on; the bench waits for hready.
// Notes:   Expected plans come from bench functions, never from the design.
`timescale 1ns/100ps
`default_nettype none
module touch_adc_config_fields_test;
    logic        hclk, hresetn, hsel, hwrite, seq_start, seq_end, busy;
    logic        hreadyout, hresp, plan_diff, plan_z34, plan_dma;
    wire logic   hready, set_done;
    logic [31:0] haddr, hwdata, hrdata, rd, wd;
    logic [1:0]  htrans, plan_axis;
    logic [2:0]  hsize, plan_vsamp;
    logic [3:0]  gap;
    int          err_count, compares, cycles, pulses;
    assign hready = hreadyout;
    tacf_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .seq_start(seq_start), .seq_end(seq_end),
        .set_done(set_done), .plan_diff(plan_diff), .plan_z34(plan_z34), .plan_dma(plan_dma),
        .plan_axis(plan_axis), .plan_vsamp(plan_vsamp));
    tacf_panel panel_u (.hclk(hclk), .hresetn(hresetn), .busy(busy), .gap(gap), .set_done(set_done));
    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    always @(posedge hclk)
    begin
        pulses <= seq_start ? 0 : pulses + int'(set_done === 1'b1);
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            err_count++;
            $display("ERROR %0t run did not finish in time", $time);
            end_of_test();
        end
    end
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [2:0] sz, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= sz;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
        check({31'h0, hresp}, 32'h0, "response");
    endtask
    // Packs {diff, dma, axis, vsamp}; axis 10 in touch mode always runs differentially.
    function automatic logic [6:0] plan_of(input logic [31:0] c, input logic touch);
        logic [1:0] ax;
        ax = touch ? c[14:13] : 2'h0;
        return {(ax == 2'h2) | c[30], touch & c[15], ax, (c[18:16] == 3'h0) ? 3'h2 : c[18:16]};
    endfunction
    task automatic run_seq(input logic [31:0] c, input logic touch);
        logic [31:0] q;
        logic [6:0]  e;
        e = plan_of(c, touch);
        bus(1'b1, tacf_pkg::CMD_OFFSET, 3'h2, touch ? {28'h0, tacf_pkg::CMD_TOUCH} : 32'h1, q);
        bus(1'b1, tacf_pkg::CFG_OFFSET, 3'h2, c, q);
        @(posedge hclk);
        seq_start <= 1'b1;
        @(posedge hclk);
        seq_start <= 1'b0;
        busy      <= 1'b1;
        gap       <= 4'($urandom_range(0, 5));
        // A write while the sequence runs must leave the captured plan alone.
        bus(1'b1, tacf_pkg::CFG_OFFSET, 3'h2, ~c, q);
        bus(1'b0, tacf_pkg::CFG_OFFSET, 3'h2, 32'h0, q);
        check(q, ~c & 32'hC007FFFF, "write during sequence");
        bus(1'b0, tacf_pkg::ACTIVE_OFFSET, 3'h2, 32'h0, q);
        check(q, 32'h1, "sequence active");
        bus(1'b0, tacf_pkg::CMD_OFFSET, 3'h2, 32'h0, q);
        check(q, touch ? 32'hC : 32'h1, "command");
        repeat (20) @(posedge hclk);
        busy <= 1'b0;
        repeat (4) @(posedge hclk);
        #1;
        check({31'h0, plan_diff}, {31'h0, e[6]}, "drive");
        check({31'h0, plan_z34}, {31'h0, c[31] & pulses[0]}, "z pair");
        check({31'h0, plan_dma}, {31'h0, e[5]}, "readout");
        check({30'h0, plan_axis}, {30'h0, e[4:3]}, "axis");
        check({29'h0, plan_vsamp}, {29'h0, e[2:0]}, "sample");
        seq_end <= 1'b1;
        @(posedge hclk);
        seq_end <= 1'b0;
    endtask
    initial
    begin
        {hresetn, hsel, hwrite, seq_start, seq_end, busy} = 6'h00;
        {haddr, hwdata, htrans, hsize, gap} = 73'h0;
        {err_count, compares, cycles, pulses} = 128'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        void'($urandom(32'h1A03));
        #1;
        check({29'h0, plan_vsamp}, 32'h2, "reset sample");
        bus(1'b0, tacf_pkg::CFG_OFFSET, 3'h2, 32'h0, rd);
        check(rd, 32'h0002002C, "reset value");
        bus(1'b0, 8'h40, 3'h2, 32'h0, rd);
        check(rd, 32'h0, "unmapped read");
        for (int i = 0; i < 6; i++)
        begin
            wd = $urandom;
            bus(1'b1, tacf_pkg::CFG_OFFSET, 3'h2, wd, rd);
            bus(1'b0, tacf_pkg::CFG_OFFSET, 3'h2, 32'h0, rd);
            check(rd, wd & 32'hC007FFFF, "read back");
        end
        bus(1'b1, tacf_pkg::CFG_OFFSET, 3'h0, ~wd, rd);
        bus(1'b0, tacf_pkg::CFG_OFFSET, 3'h2, 32'h0, rd);
        check(rd, wd & 32'hC007FFFF, "byte write dropped");
        for (int i = 0; i < 8; i++)
        begin
            wd          = $urandom;
            wd[18:16]   = 3'(i);
            // The last pass sets axis 10 outside touch mode, where it must not force differential drive.
            wd[14:13]   = (i == 7) ? 2'h2 : 2'(i % 3);
            wd[31]      = (i % 4) < 2;
            run_seq(wd, i != 7);
        end
        @(posedge hclk);
        hresetn <= 1'b0;
        @(posedge hclk);
        check({29'h0, plan_vsamp}, 32'h2, "mid reset sample");
        hresetn <= 1'b1;
        bus(1'b0, tacf_pkg::CFG_OFFSET, 3'h2, 32'h0, rd);
        check(rd, 32'h0002002C, "mid reset value");
        end_of_test();
    end
endmodule
`default_nettype wire
